//--- src/tc8_bit_latch.sv
// Receive and transmit bit latches clocked by the counter carry
`timescale 1ns/1ps
module tc8_bit_latch (
	input wire logic clk,
	input wire logic resetn,
	tc8_if.latch lk
);
	logic rx_r;
	logic tx_r;
	assign lk.rx_bit = rx_r;
	assign lk.tx_out = tx_r;
	// R8 R9: sample input on carry
	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_r <= 1'b1;
		end else if (lk.carry) begin
			rx_r <= lk.rx_level;
		end
	end
	// R9 R10: shift one bit per interval
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_r <= 1'b1;
		end else if (lk.carry) begin
			tx_r <= lk.tx_bit;
		end
	end
endmodule : tc8_bit_latch

//--- src/tc8_if.sv
// Interface between timer core and serial bit latches
`timescale 1ns/1ps
interface tc8_if;
	logic carry;
	logic tx_bit;
	logic rx_level;
	logic rx_bit;
	logic tx_out;
	modport core (output carry, output tx_bit, output rx_level,
		input rx_bit, input tx_out);
	modport latch (input carry, input tx_bit, input rx_level,
		output rx_bit, output tx_out);
endinterface : tc8_if

//--- src/tc8_pkg.sv
// Constants for the 8-bit timer with serial assist
package tc8_pkg;
	localparam int CNT_W = 8;
	localparam logic [1:0] SRC_FAST = 2'h0;
	localparam logic [1:0] SRC_AUX = 2'h1;
	localparam logic [1:0] SRC_PIN = 2'h2;
	localparam logic [1:0] SRC_FAST_AND_PIN = 2'h3;
	localparam logic [7:0] PRELOAD_RST = 8'h00;
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_ENABLE = 2;
	localparam int CTRL_START_DET = 3;
	localparam int CTRL_TX_DRIVE = 4;
	localparam int AUX_DIV_DEFAULT = 32;
endpackage : tc8_pkg

//--- src/tc8_timer.sv
// 8-bit preloadable timer/counter with start detect and bit latches
// How it works
// R1: 8-bit counter, preload and control registers
// R2: Two control bits pick clock source
// R3: Counter write loads preload, not data
// R4: Preload buffers, rewritable after load
// R5: Preload readable and writable by software
// R6: Enable high counts rising edges, else hold
// R7: Start detect holds counter until edge
// R8: First interval end samples serial input
// R9: Carry clocks receive and transmit latches
// R10: Transmit bits driven one per interval
// R11: Shared pins carry timer signals
// R12: Aux clock slower, fast is multiple
// R13: Carry reloads counter from preload
`timescale 1ns/1ps
module tc8_timer
	import tc8_pkg::*;
#(
	parameter int AUX_DIV = AUX_DIV_DEFAULT
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic preload_we,
	input wire logic [7:0] preload_wdata,
	input wire logic ctrl_we,
	input wire logic [7:0] ctrl_wdata,
	input wire logic count_we,
	input wire logic tx_bit,
	input wire logic first_shared_pin,
	input wire logic second_shared_pin,
	output logic [7:0] preload_rdata,
	output logic [7:0] ctrl_rdata,
	output logic [7:0] count_rdata,
	output logic receive_bit_latch,
	output logic transmit_bit_latch,
	output logic tx_pin_out,
	output logic tx_pin_oe,
	output logic carry_pulse,
	output logic waiting_start
);
	typedef enum logic [1:0] {IDLE, ARMED, RUN} state_type;
	state_type state_r;
	logic [7:0] preload_r;
	logic [7:0] ctrl_r;
	logic [7:0] count_r;
	logic [7:0] aux_cnt_r;
	logic aux_tick;
	logic pin_d_r;
	logic rx_d_r;
	logic src_tick;
	logic step;
	logic carry;
	logic rearm;
	logic start_edge;
	tc8_if lk ();

	// R4 R5: preload buffer store
	// Never touches the count, so it may be rewritten after a load
	always_ff @(posedge clk) begin
		if (!resetn) begin
			preload_r <= PRELOAD_RST;
		end else if (preload_we) begin
			preload_r <= preload_wdata;
		end
	end

	// R1: control store
	always_ff @(posedge clk) begin
		if (!resetn) begin
			ctrl_r <= CTRL_RST;
		end else if (ctrl_we) begin
			ctrl_r <= ctrl_wdata;
		end
	end

	// R12: aux tick divider
	// Crystal stand-in: a one-cycle enable, not a second clock
	always_ff @(posedge clk) begin
		if (!resetn) begin
			aux_cnt_r <= 8'h00;
		end else if (aux_tick) begin
			aux_cnt_r <= 8'h00;
		end else begin
			aux_cnt_r <= aux_cnt_r + 8'h01;
		end
	end
	assign aux_tick = (aux_cnt_r == 8'(AUX_DIV - 1));

	// Pin history for edge detection
	// Receive history resets high so an idle line gives no edge
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_d_r <= 1'b0;
			rx_d_r <= 1'b1;
		end else begin
			pin_d_r <= first_shared_pin;
			rx_d_r <= second_shared_pin;
		end
	end

	// R2: clock source select
	always_comb begin
		case (ctrl_r[CTRL_SRC_LSB +: 2])
			SRC_FAST: src_tick = 1'b1;
			SRC_AUX: src_tick = aux_tick;
			// Pins are synchronous; an edge is judged on the last sample
			SRC_PIN: src_tick = first_shared_pin & ~pin_d_r;
			// Fast clock gated by pin counts fast edges while pin high
			SRC_FAST_AND_PIN: src_tick = first_shared_pin;
			default: src_tick = 1'b0;
		endcase
	end

	// R7: re-arm on control write
	assign rearm = ctrl_we && ctrl_wdata[CTRL_START_DET];
	// R7: falling receive edge
	assign start_edge = rx_d_r & ~second_shared_pin;

	// R7: start bit detector
	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= IDLE;
		end else begin
			case (state_r)
				// Leaves IDLE one cycle after reset
				IDLE: begin
					if (ctrl_r[CTRL_START_DET]) begin
						state_r <= ARMED;
					end else begin
						state_r <= RUN;
					end
				end
				// Dropping start detect while armed just runs
				ARMED: begin
					if (!ctrl_r[CTRL_START_DET]) begin
						state_r <= RUN;
					end else if (start_edge) begin
						state_r <= RUN;
					end
				end
				// Judged on the written value, so one write arms
				RUN: begin
					if (rearm) begin
						state_r <= ARMED;
					end
				end
				default: state_r <= IDLE;
			endcase
		end
	end

	// R6: count only when enabled
	assign step = ctrl_r[CTRL_ENABLE] && state_r == RUN && src_tick;
	// Carry is the last step of an interval, not an extra one
	assign carry = step && count_r == 8'hFF;

	// A load wins over a carry in the same cycle
	always_ff @(posedge clk) begin
		if (!resetn) begin
			count_r <= COUNT_RST;
		end else if (count_we) begin
			// R3: write loads preload
			count_r <= preload_r;
		end else if (carry) begin
			// R13: reload on carry
			count_r <= preload_r;
		end else if (step) begin
			count_r <= count_r + 8'h01;
		end
	end

	assign lk.carry = carry;
	// Taken only at a carry, so software may change it at will
	assign lk.tx_bit = tx_bit;
	assign lk.rx_level = second_shared_pin;

	tc8_bit_latch u_latch (
		.clk(clk),
		.resetn(resetn),
		.lk(lk)
	);

	// R1 R5: readback copies
	// Copies lag the stores by one cycle; every output is a flop
	always_ff @(posedge clk) begin
		if (!resetn) begin
			preload_rdata <= PRELOAD_RST;
			ctrl_rdata <= CTRL_RST;
			count_rdata <= COUNT_RST;
		end else begin
			preload_rdata <= preload_r;
			ctrl_rdata <= ctrl_r;
			count_rdata <= count_r;
		end
	end

	// R9: carry and start status
	always_ff @(posedge clk) begin
		if (!resetn) begin
			carry_pulse <= 1'b0;
			waiting_start <= 1'b0;
		end else begin
			carry_pulse <= carry;
			waiting_start <= (state_r == ARMED);
		end
	end

	// R11: shared pin drive
	// Enable follows control; the output idles high
	always_ff @(posedge clk) begin
		if (!resetn) begin
			receive_bit_latch <= 1'b1;
			transmit_bit_latch <= 1'b1;
			tx_pin_out <= 1'b1;
			tx_pin_oe <= 1'b0;
		end else begin
			receive_bit_latch <= lk.rx_bit;
			transmit_bit_latch <= lk.tx_out;
			// R10: transmit on pin
			tx_pin_out <= lk.tx_out;
			tx_pin_oe <= ctrl_r[CTRL_TX_DRIVE];
		end
	end
endmodule : tc8_timer

//--- test/tb.sv
// Self-checking bench for the 8-bit timer
`timescale 1ns/1ps
module tb;
	logic clk = 1'b0;
	logic resetn, preload_we, ctrl_we, count_we, tx_bit, send;
	logic first_shared_pin, second_shared_pin, receive_bit_latch;
	logic transmit_bit_latch, tx_pin_out, tx_pin_oe, carry_pulse;
	logic waiting_start;
	logic [7:0] preload_wdata, ctrl_wdata, preload_rdata;
	logic [7:0] ctrl_rdata, count_rdata;
	wire [3:0] pin_view = {transmit_bit_latch, tx_pin_out, tx_pin_oe,
		receive_bit_latch};
	int n_mismatch = 0;
	int total_checks = 0;
	tc8_timer #(.AUX_DIV(4)) u_dut (.*);
	tc8_serial_peer u_peer (.clk, .resetn, .send, .line(second_shared_pin));
	initial forever #2.5 clk = ~clk;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] w, input logic [7:0] d);
		@(posedge clk) {preload_we, ctrl_we, count_we} <= w;
		{preload_wdata, ctrl_wdata} <= {d, d};
		@(posedge clk) {preload_we, ctrl_we, count_we} <= 3'h0;
	endtask : wr
	task automatic t_src;
		// Pin pattern 1110 gives 4 rising edges and 12 high cycles
		logic [7:0] want [4] = '{8'hF8, 8'hF6, 8'hF4, 8'hFC};
		wr(3'h4, 8'hF0);
		for (int s = 0; s < 4; s++) begin
			wr(3'h1, 8'h00);
			wr(3'h2, 8'h04 | 8'(s));
			for (int i = 0; i < 16; i++) begin
				@(posedge clk) first_shared_pin <= (i % 4) != 3;
			end
			repeat (6) @(posedge clk);
			wr(3'h2, 8'h00);
			repeat (3) @(posedge clk);
			#1 chk({8'h00, count_rdata}, {8'h00, want[s]});
		end
	endtask : t_src
	task automatic t_start;
		wr(3'h4, 8'hF8);
		wr(3'h1, 8'h00);
		wr(3'h4, 8'hF4);
		wr(3'h2, 8'h1C);
		repeat (4) @(posedge clk);
		#1 chk({7'h00, waiting_start, count_rdata}, 16'h01F8);
		chk({preload_rdata, ctrl_rdata}, 16'hF41C);
		@(posedge clk) send <= 1'b1;
		tx_bit <= 1'b1;
		@(posedge clk) send <= 1'b0;
		#1 for (int i = 0; i < 400 && carry_pulse !== 1'b1; i++) #5;
		chk({15'h0000, carry_pulse}, 16'h0001);
		@(posedge clk);
		#1 chk({12'h000, pin_view}, 16'h000E);
	endtask : t_start
	task automatic t_reset;
		@(posedge clk) resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1 chk({preload_rdata, ctrl_rdata}, 16'h0000);
		chk({count_rdata, 6'h00, waiting_start, carry_pulse}, 16'h0000);
		chk({12'h000, pin_view}, 16'h000D);
		repeat (3) @(posedge clk);
		#1 chk({7'h00, waiting_start, count_rdata}, 16'h0000);
	endtask : t_reset
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		{resetn, preload_we, ctrl_we, count_we, tx_bit, send} = 6'h00;
		{first_shared_pin, preload_wdata, ctrl_wdata} = 17'h00000;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		t_src();
		t_start();
		t_reset();
		end_of_test();
	end
	initial begin
		#20000 n_mismatch++;
		end_of_test();
	end
endmodule : tb

//--- test/tc8_properties.sv
// Port assertions for the 8-bit timer
`timescale 1ns/1ps
module tc8_properties (
	input logic clk,
	input logic resetn,
	input logic count_we,
	input logic [7:0] preload_rdata,
	input logic [7:0] ctrl_rdata,
	input logic [7:0] count_rdata,
	input logic receive_bit_latch,
	input logic tx_pin_out,
	input logic tx_pin_oe,
	input logic carry_pulse,
	input logic waiting_start
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	// Three samples cover the lag of the readback copies
	sequence run_s; (ctrl_rdata[3:0] == 4'h4 && !count_we)[*3]; endsequence
	AST_HOLD: assert property ((!ctrl_rdata[2] && !count_we)[*3] |=>
		$stable(count_rdata)) else $error("hold");
	AST_STEP: assert property (run_s ##0 count_rdata != 8'hFF |=>
		count_rdata == $past(count_rdata) + 8'h01) else $error("step");
	AST_RELOAD: assert property (run_s ##0 count_rdata == 8'hFF |=>
		count_rdata == $past(preload_rdata)) else $error("reload");
	AST_LOAD: assert property (count_we |-> ##2
		count_rdata == $past(preload_rdata)) else $error("load");
	AST_WAIT: assert property ((waiting_start && !count_we)[*3] |=>
		$stable(count_rdata)) else $error("wait");
	AST_TX: assert property ($changed(tx_pin_out) |->
		$past(carry_pulse)) else $error("tx");
	AST_RX: assert property ($changed(receive_bit_latch) |->
		$past(carry_pulse)) else $error("rx");
	AST_TOP: assert property (carry_pulse |-> count_rdata == 8'hFF ||
		$past(count_rdata) == 8'hFF) else $error("top");
	AST_OE: assert property (tx_pin_oe == ctrl_rdata[4])
		else $error("oe");
endmodule : tc8_properties
bind tc8_timer tc8_properties u_props (.*);

//--- test/tc8_serial_peer.sv
// Serial partner that sends a 16-clock start bit
`timescale 1ns/1ps
module tc8_serial_peer (
	input logic clk,
	input logic resetn,
	input logic send,
	output logic line
);
	logic [4:0] left_r;
	always_ff @(posedge clk) begin
		left_r <= !resetn ? 5'h00 : send ? 5'h10 : left_r - {4'h0, |left_r};
	end
	// Idles high between frames, as the pull-up would
	assign line = ~|left_r;
endmodule : tc8_serial_peer
